// ==== dv/mshr_bus_master.sv ====
// Register bus master standing in for the serial frame layer
`timescale 1ns/10ps
module mshr_bus_master (
    // Clock
    input  wire logic        clk_i,
    // Request
    output logic             req_valid_o,
    output logic      [7:0]  req_func_o,
    output logic      [15:0] req_addr_o,
    output logic      [15:0] req_wdata_o,
    // Answer
    input  wire logic        rsp_valid_i,
    input  wire logic [15:0] rsp_rdata_i,
    input  wire logic        rsp_exc_i,
    input  wire logic [7:0]  rsp_exc_code_i
);
    initial begin
        req_valid_o = 1'b0;
        req_func_o  = 8'h00;
        req_addr_o  = 16'h0000;
        req_wdata_o = 16'h0000;
    end

    // One word per request, answer taken one edge later
    task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] rd,
                        output logic [7:0] ec, output logic ef,
                        output logic ok);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_func_o  <= f;
        req_addr_o  <= a;
        req_wdata_o <= d;
        @(posedge clk_i);
        // Address and data fields flip so stale values never look valid
        req_valid_o <= 1'b0;
        req_addr_o  <= ~a;
        req_wdata_o <= ~d;
        #1;
        ok = rsp_valid_i;
        rd = rsp_rdata_i;
        ec = rsp_exc_code_i;
        ef = rsp_exc_i;
    endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the holding register bank
`timescale 1ns/10ps
module tb;
    import mshr_pkg::*;
    localparam int TK = 8;
    logic        clk   = 1'b0;
    logic        rst_b = 1'b0;
    logic        mb    = 1'b0;
    logic        ovr   = 1'b0;
    logic        asc   = 1'b1;
    logic        rmt   = 1'b0;
    logic        anl   = 1'b0;
    logic        rv, rx, fa, sp, rp, b_off, b_kick, b_rmt, b_anl;
    logic        rv_o_w;
    logic [7:0]  rf, rc;
    logic [15:0] ra, rw, rr;
    wire  [15:0] so [10];
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          seed = 32'h8d03e789;
    int          rnum [10] = '{13, 14, 15, 16, 17, 18, 19, 20, 21, 31};
    int          rrst [10] = '{100, 30, 0, 0, 1, 10, 0, 0, 60, 0};
    int          rlo [10] = '{75, 30, 0, 0, 0, 0, 0, 0, 0, 30};
    int          rhi [10] = '{100, 70, 1, 40, 1, 60, 1, 1, 200, 100};
    int          mv [10];
    int          fn [3] = '{3, 6, 16};
    int          bf [4] = '{1, 4, 5, 23};
    int          tv [6] = '{0, 59, 60, 100, 101, 40};

    assign so[2] = {15'h0000, b_off};
    assign so[4] = {15'h0000, b_kick};
    assign so[6] = {15'h0000, b_rmt};
    assign so[7] = {15'h0000, b_anl};

    always #2 clk = ~clk;

    mshr_top #(.TICK_CYCLES(TK)) dut (
        .clk_i(clk), .rst_b_i(rst_b), .req_valid_i(rv), .req_func_i(rf),
        .req_addr_i(ra), .req_wdata_i(rw), .rsp_valid_o(rv_o_w),
        .rsp_rdata_o(rr), .rsp_exc_o(rx), .rsp_exc_code_o(rc),
        .modbus_mode_i(mb), .override_en_i(ovr), .asc_mode_i(asc),
        .remote_in_i(rmt), .analog_logic_in_i(anl),
        .upper_limit_o(so[0]), .lower_limit_o(so[1]),
        .off_level_en_o(b_off), .off_level_thr_o(so[3]),
        .kick_start_o(b_kick), .start_dur_o(so[5]),
        .remote_timer_o(b_rmt), .analog_logic_o(b_anl),
        .run_time_o(so[8]), .force_active_o(fa), .force_level_o(so[9]),
        .start_phase_o(sp), .run_phase_o(rp));

    mshr_bus_master m (
        .clk_i(clk), .req_valid_o(rv), .req_func_o(rf), .req_addr_o(ra),
        .req_wdata_o(rw), .rsp_valid_i(rv_o_w), .rsp_rdata_i(rr),
        .rsp_exc_i(rx), .rsp_exc_code_i(rc));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic bit legal(int i, int v);
        if (i == 9 && v == 0) return 1'b1;
        if (i == 3 && asc !== 1'b1) return v >= 60 && v <= 100;
        return v >= rlo[i] && v <= rhi[i];
    endfunction

    // Model one request, then compare the answer
    task automatic acc(input int f, input int a, input int d);
        logic [15:0] rd;
        logic [7:0]  ec;
        logic        ef, ok;
        int          i, er, ee;
        // Model after the transfer: sees inputs as the design took them
        m.xfer(f[7:0], a[15:0], d[15:0], rd, ec, ef, ok);
        i = -1;
        foreach (rnum[k]) if (rnum[k] == a) i = k;
        ee = 0;
        er = 0;
        if (f != 3 && f != 6 && f != 16) ee = 1;
        else if (a < 13 || a > 40) ee = 2;
        else if (f == 3) er = (i < 0) ? 0 : mv[i];
        else begin
            er = d & 16'hffff;
            if (i >= 0 && legal(i, d)) mv[i] = d;
            else if (i >= 0) begin
                ee = 3;
                er = 0;
            end
        end
        check(16'(ok), 16'h0001);
        check(rd, er[15:0]);
        check(16'(ec), ee[15:0]);
        check(16'(ef), 16'(ee != 0));
    endtask

    // Settings in force: stored values in Modbus mode, else defaults
    task automatic chkset();
        repeat (2) @(posedge clk);
        #1;
        foreach (mv[k]) check(so[k], mb ? mv[k][15:0] : rrst[k][15:0]);
        check(16'(fa), 16'(mb & ovr));
    endtask

    task automatic phase_len(input bit run, output int n);
        n = 0;
        while ((run ? rp : sp) === 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic timer_run(input bit use_an);
        int n;
        acc(6, 19, !use_an);
        acc(6, 20, use_an);
        acc(6, 18, 2);
        acc(6, 21, 3);
        @(posedge clk);
        mb <= 1'b0;
        rmt <= !use_an;
        anl <= use_an;
        repeat (6) @(posedge clk);
        #1;
        check(16'(sp), 16'h0000);
        @(posedge clk);
        rmt <= 1'b0;
        anl <= 1'b0;
        mb <= 1'b1;
        repeat (3) @(posedge clk);
        rmt <= !use_an;
        anl <= use_an;
        n = 0;
        while (sp !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(sp), 16'h0001);
        phase_len(1'b0, n);
        check(16'(n >= 2 * TK && n <= 3 * TK + 1), 16'h0001);
        check(16'(rp), 16'h0001);
        phase_len(1'b1, n);
        check(16'(n >= 3 * TK && n <= 4 * TK + 1), 16'h0001);
        @(posedge clk);
        rmt <= 1'b0;
        anl <= 1'b0;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        foreach (mv[k]) mv[k] = rrst[k];
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chkset();
        foreach (rnum[i]) acc(3, rnum[i], 0);
        $display("test defaults done");
        foreach (rnum[i]) begin
            int v [4];
            v = '{rlo[i] - 1, rlo[i], rhi[i], rhi[i] + 1};
            foreach (v[j]) acc(j[0] ? 16 : 6, rnum[i], v[j]);
            acc(3, rnum[i], 0);
        end
        acc(6, 31, 0);
        @(posedge clk);
        asc <= 1'b0;
        foreach (tv[j]) acc(6, 16, tv[j]);
        $display("test ranges done");
        foreach (bf[k]) acc(bf[k], 14, 50);
        foreach (fn[k]) begin
            acc(fn[k], 12, 40);
            acc(fn[k], 41, 40);
            acc(fn[k], 25, 7);
            acc(fn[k], 40, 9);
        end
        $display("test refusals done");
        repeat (60) begin
            @(posedge clk);
            asc <= 1'($random(seed));
            @(posedge clk);
            acc(fn[($random(seed) & 3) % 3], 13 + (($random(seed) & 255) % 28),
                $random(seed) & 255);
        end
        acc(6, 31, 55);
        chkset();
        @(posedge clk);
        mb <= 1'b1;
        ovr <= 1'b1;
        chkset();
        $display("test random and gating done");
        timer_run(1'b0);
        timer_run(1'b1);
        $display("test timer done");
        complete_run();
    end
endmodule

// ==== rtl/mshr_pkg.sv ====
// Constants and types for the motor speed holding register bank
package mshr_pkg;

    // Clock and one-second timing base
    localparam int CLK_PERIOD_NS = 4;
    localparam int SECOND_NS     = 1000000000;
    localparam int TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;

    // Function codes and exception codes
    localparam logic [7:0] FUNC_RD_HOLD = 8'h03;
    localparam logic [7:0] FUNC_WR_ONE  = 8'h06;
    localparam logic [7:0] FUNC_WR_MANY = 8'h10;
    localparam logic [7:0] EXC_NONE     = 8'h00;
    localparam logic [7:0] EXC_FUNC     = 8'h01;
    localparam logic [7:0] EXC_ADDR     = 8'h02;
    localparam logic [7:0] EXC_DATA     = 8'h03;

    // Span of register numbers served here, reserved holes included
    localparam logic [15:0] MAP_FIRST = 16'h000d;
    localparam logic [15:0] MAP_LAST  = 16'h0028;

    // Register indices
    localparam int NREG       = 10;
    localparam int IDX_UPPER  = 0;
    localparam int IDX_LOWER  = 1;
    localparam int IDX_OFF_EN = 2;
    localparam int IDX_THR    = 3;
    localparam int IDX_STYLE  = 4;
    localparam int IDX_DUR    = 5;
    localparam int IDX_REMOTE = 6;
    localparam int IDX_ANALOG = 7;
    localparam int IDX_RUN    = 8;
    localparam int IDX_FORCE  = 9;

    // Per register: number, reset value, legal minimum and maximum
    localparam logic [15:0] REG_NUM [NREG] = '{
        16'h000d, 16'h000e, 16'h000f, 16'h0010, 16'h0011,
        16'h0012, 16'h0013, 16'h0014, 16'h0015, 16'h001f};
    localparam logic [15:0] REG_RST [NREG] = '{
        16'h0064, 16'h001e, 16'h0000, 16'h0000, 16'h0001,
        16'h000a, 16'h0000, 16'h0000, 16'h003c, 16'h0000};
    localparam logic [15:0] REG_MIN [NREG] = '{
        16'h004b, 16'h001e, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h001e};
    localparam logic [15:0] REG_MAX [NREG] = '{
        16'h0064, 16'h0046, 16'h0001, 16'h0064, 16'h0001,
        16'h003c, 16'h0001, 16'h0001, 16'h00c8, 16'h0064};
    // Zero is legal outside the min..max span
    localparam logic [NREG-1:0] REG_ZERO_OK = 10'h200;

    // Off-level threshold bounds per input direction
    localparam logic [15:0] THR_ASC_MAX = 16'h0028;
    localparam logic [15:0] THR_DSC_MIN = 16'h003c;
    localparam logic [15:0] THR_DSC_MAX = 16'h0064;

    typedef enum logic [1:0] {PH_IDLE, PH_START, PH_RUN} mshr_phase_t;

endpackage

// ==== rtl/mshr_reg_cell.sv ====
// One holding register with its power-up value
`timescale 1ns/10ps
module mshr_reg_cell #(
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Qualified write
    input  wire logic        wr_i,
    input  wire logic [15:0] data_i,
    // Stored value
    output logic      [15:0] q_o
);
    import mshr_pkg::*;

    logic [15:0] q_reg;
    logic [15:0] q_next;

    always_comb begin
        q_next = wr_i ? data_i : q_reg;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;

    hold_when_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !wr_i |=> q_o == $past(q_o))
        else $error("register changed without a write");

endmodule

// ==== rtl/mshr_run_timer.sv ====
// Start phase followed by operation phase, counted in seconds
`timescale 1ns/10ps
module mshr_run_timer (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // Control
    input  wire logic                 en_i,
    input  wire logic                 trig_i,
    input  wire logic                 tick_i,
    input  wire logic [7:0]           start_dur_i,
    input  wire logic [7:0]           run_time_i,
    // Status
    output mshr_pkg::mshr_phase_t     phase_o,
    output logic      [7:0]           remain_o
);
    import mshr_pkg::*;

    mshr_phase_t phase_reg;
    mshr_phase_t phase_next;
    logic [7:0]  cnt_reg;
    logic [7:0]  cnt_next;
    logic        trig_reg;
    logic        go;

    assign go = trig_i && !trig_reg;

    always_comb begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        case (phase_reg)
            PH_IDLE: begin
                if (en_i && go) begin
                    phase_next = PH_START;
                    cnt_next   = start_dur_i;
                end
            end
            PH_START: begin
                if (tick_i) begin
                    if (cnt_reg == 8'h00) begin
                        // Operation time comes on top of start time
                        phase_next = PH_RUN;
                        cnt_next   = run_time_i;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
            end
            PH_RUN: begin
                if (tick_i) begin
                    if (cnt_reg == 8'h00) begin
                        phase_next = PH_IDLE;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
            end
            default: phase_next = PH_IDLE;
        endcase
        if (!en_i) begin
            phase_next = PH_IDLE;
            cnt_next   = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= 8'h00;
            trig_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            trig_reg  <= trig_i;
        end
    end

    assign phase_o  = phase_reg;
    assign remain_o = cnt_reg;

    sequence s_launch;
        phase_reg == PH_IDLE && en_i && go;
    endsequence

    sequence s_start_done;
        phase_reg == PH_START && en_i && tick_i && cnt_reg == 8'h00;
    endsequence

    launch_loads_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_launch |=> phase_reg == PH_START
            && cnt_reg == $past(start_dur_i))
        else $error("start phase not loaded");

    start_to_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_start_done |=> phase_reg == PH_RUN
            && cnt_reg == $past(run_time_i))
        else $error("operation phase not loaded after start");

    disabled_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !en_i |=> phase_reg == PH_IDLE)
        else $error("timer runs while not enabled");

endmodule

// ==== rtl/mshr_top.sv ====
// Holding register bank 13..40 with mode gating and operation timer
// Behaviour
// - Upper output limit 75..100 percent of supply, power-up value 100.
// - Lower output limit 30..70 percent of supply, power-up value 30.
// - Off-level enable, 0 off, 1 on, power-up value 0.
// - Off-level threshold 0..40 ascending or 60..100 descending, default 0.
// - Start style select, 0 soft start, 1 kick start, default 1.
// - Start duration 0..60 whole seconds, default 10.
// - Remote input function, 0 normal, 1 timer, default 0.
// - Analogue input function, 0 normal, 1 logic, default 0.
// - Operation time 0..200 seconds, default 60, used in timer/logic mode.
// - Operation time runs after, not inside, the start duration.
// - Timer runs only in Modbus mode with timer or logic mode set.
// - Override value 0 or 30..100, applied only while override enabled.
// - Legal writes accepted in either mode; settings act only in Modbus mode.
// - Serve read holding, write single and write multiple functions only.
// - Mode 0 standalone with local controls, 1 Modbus mode.
// - Override enable gives direct output control, only in Modbus mode.
`timescale 1ns/10ps
module mshr_top #(
    parameter int TICK_CYCLES = mshr_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Decoded request, one register word per cycle
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    // Answer
    output logic             rsp_valid_o,
    output logic      [15:0] rsp_rdata_o,
    output logic             rsp_exc_o,
    output logic      [7:0]  rsp_exc_code_o,
    // Device state held outside this bank
    input  wire logic        modbus_mode_i,
    input  wire logic        override_en_i,
    input  wire logic        asc_mode_i,
    input  wire logic        remote_in_i,
    input  wire logic        analog_logic_in_i,
    // Settings in force
    output logic      [15:0] upper_limit_o,
    output logic      [15:0] lower_limit_o,
    output logic             off_level_en_o,
    output logic      [15:0] off_level_thr_o,
    output logic             kick_start_o,
    output logic      [15:0] start_dur_o,
    output logic             remote_timer_o,
    output logic             analog_logic_o,
    output logic      [15:0] run_time_o,
    output logic             force_active_o,
    output logic      [15:0] force_level_o,
    // Timer status
    output logic             start_phase_o,
    output logic             run_phase_o
);
    import mshr_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////
    // Request decode

    logic            is_read;
    logic            is_write;
    logic            in_map;
    logic [NREG-1:0] match;
    logic [NREG-1:0] legal;
    logic [15:0]     q [NREG];
    logic            wr_go;
    logic            hit;
    logic            hit_legal;
    logic [15:0]     rd_data;

    assign is_read  = req_func_i == FUNC_RD_HOLD;
    assign is_write = req_func_i == FUNC_WR_ONE
                   || req_func_i == FUNC_WR_MANY;
    assign in_map   = req_addr_i >= MAP_FIRST && req_addr_i <= MAP_LAST;
    // Reserved holes fall through with no match
    assign wr_go    = req_valid_i && is_write && in_map;

    ////////////////////////////////////////////////////////////////////
    // Register cells

    for (genvar g = 0; g < NREG; g++) begin : g_cell
        assign match[g] = req_addr_i == REG_NUM[g];
        if (g == IDX_THR) begin : g_thr
            // Legal span follows the analogue input direction
            assign legal[g] = asc_mode_i
                ? req_wdata_i <= THR_ASC_MAX
                : req_wdata_i >= THR_DSC_MIN
                  && req_wdata_i <= THR_DSC_MAX;
        end else begin : g_std
            assign legal[g] = (req_wdata_i >= REG_MIN[g]
                               && req_wdata_i <= REG_MAX[g])
                           || (REG_ZERO_OK[g] && req_wdata_i == 16'h0000);
        end
        mshr_reg_cell #(
            .RST_VAL (REG_RST[g])
        ) u_cell (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .wr_i    (wr_go && match[g] && legal[g]),
            .data_i  (req_wdata_i),
            .q_o     (q[g])
        );
    end

    always_comb begin
        hit       = 1'b0;
        hit_legal = 1'b0;
        rd_data   = 16'h0000;
        for (int i = 0; i < NREG; i++) begin
            if (match[i]) begin
                hit       = 1'b1;
                hit_legal = legal[i];
                rd_data   = q[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Answer

    logic        rsp_valid_reg;
    logic        rsp_valid_next;
    logic [15:0] rsp_rdata_reg;
    logic [15:0] rsp_rdata_next;
    logic        rsp_exc_reg;
    logic        rsp_exc_next;
    logic [7:0]  rsp_code_reg;
    logic [7:0]  rsp_code_next;

    always_comb begin
        rsp_valid_next = req_valid_i;
        rsp_rdata_next = 16'h0000;
        rsp_exc_next   = 1'b0;
        rsp_code_next  = EXC_NONE;
        if (req_valid_i) begin
            if (!is_read && !is_write) begin
                rsp_exc_next  = 1'b1;
                rsp_code_next = EXC_FUNC;
            end else if (!in_map) begin
                rsp_exc_next  = 1'b1;
                rsp_code_next = EXC_ADDR;
            end else if (is_write && hit && !hit_legal) begin
                rsp_exc_next  = 1'b1;
                rsp_code_next = EXC_DATA;
            end else if (is_read) begin
                rsp_rdata_next = rd_data;
            end else begin
                // Write answer echoes the word
                rsp_rdata_next = req_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 16'h0000;
            rsp_exc_reg   <= 1'b0;
            rsp_code_reg  <= EXC_NONE;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            rsp_exc_reg   <= rsp_exc_next;
            rsp_code_reg  <= rsp_code_next;
        end
    end

    assign rsp_valid_o    = rsp_valid_reg;
    assign rsp_rdata_o    = rsp_rdata_reg;
    assign rsp_exc_o      = rsp_exc_reg;
    assign rsp_exc_code_o = rsp_code_reg;

    ////////////////////////////////////////////////////////////////////
    // One-second tick

    logic [31:0] tick_cnt_reg;
    logic [31:0] tick_cnt_next;
    logic        tick;

    assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

    always_comb begin
        tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operation timer

    logic        timer_en;
    logic        timer_trig;
    mshr_phase_t phase;

    assign timer_en   = modbus_mode_i
        && (q[IDX_REMOTE][0] || q[IDX_ANALOG][0]);
    assign timer_trig = (q[IDX_REMOTE][0] && remote_in_i)
                     || (q[IDX_ANALOG][0] && analog_logic_in_i);

    mshr_run_timer u_timer (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .en_i        (timer_en),
        .trig_i      (timer_trig),
        .tick_i      (tick),
        .start_dur_i (q[IDX_DUR][7:0]),
        .run_time_i  (q[IDX_RUN][7:0]),
        .phase_o     (phase),
        .remain_o    ()
    );

    ////////////////////////////////////////////////////////////////////
    // Settings in force

    // Standalone mode hands control to local switches; outputs show defaults, reads still return stored values
    logic [15:0] eff      [NREG];
    logic [15:0] eff_reg  [NREG];
    logic        force_next;
    logic        force_reg;
    logic        start_ph_reg;
    logic        run_ph_reg;

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            eff[i] = modbus_mode_i ? q[i] : REG_RST[i];
        end
        force_next = modbus_mode_i && override_en_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NREG; i++) begin
                eff_reg[i] <= REG_RST[i];
            end
            force_reg    <= 1'b0;
            start_ph_reg <= 1'b0;
            run_ph_reg   <= 1'b0;
        end else begin
            for (int i = 0; i < NREG; i++) begin
                eff_reg[i] <= eff[i];
            end
            force_reg    <= force_next;
            start_ph_reg <= phase == PH_START;
            run_ph_reg   <= phase == PH_RUN;
        end
    end

    assign upper_limit_o   = eff_reg[IDX_UPPER];
    assign lower_limit_o   = eff_reg[IDX_LOWER];
    assign off_level_en_o  = eff_reg[IDX_OFF_EN][0];
    assign off_level_thr_o = eff_reg[IDX_THR];
    assign kick_start_o    = eff_reg[IDX_STYLE][0];
    assign start_dur_o     = eff_reg[IDX_DUR];
    assign remote_timer_o  = eff_reg[IDX_REMOTE][0];
    assign analog_logic_o  = eff_reg[IDX_ANALOG][0];
    assign run_time_o      = eff_reg[IDX_RUN];
    assign force_active_o  = force_reg;
    assign force_level_o   = eff_reg[IDX_FORCE];
    assign start_phase_o   = start_ph_reg;
    assign run_phase_o     = run_ph_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks

    answer_follows_a: assert property (
        req_valid_i |=> rsp_valid_o ##1 !rsp_valid_o || $past(req_valid_i))
        else $error("request not answered next cycle");

    bad_func_a: assert property (
        req_valid_i && !is_read && !is_write
        |=> rsp_exc_o && rsp_exc_code_o == EXC_FUNC)
        else $error("unsupported function not refused");

    range_keep_a: assert property (
        req_valid_i && is_write && req_addr_i == REG_NUM[IDX_UPPER]
        && req_wdata_i > REG_MAX[IDX_UPPER]
        |=> rsp_exc_code_o == EXC_DATA && q[IDX_UPPER] == $past(q[IDX_UPPER]))
        else $error("out-of-range write stored or not refused");

    write_lands_a: assert property (
        req_valid_i && is_write && req_addr_i == REG_NUM[IDX_DUR]
        && req_wdata_i <= REG_MAX[IDX_DUR]
        |=> !rsp_exc_o && q[IDX_DUR] == $past(req_wdata_i))
        else $error("legal write not stored");

    reserved_zero_a: assert property (
        req_valid_i && is_read && in_map && !hit
        |=> !rsp_exc_o && rsp_rdata_o == 16'h0000)
        else $error("reserved position read not zero");

    mode_gate_a: assert property (
        !modbus_mode_i |=> upper_limit_o == REG_RST[IDX_UPPER]
            && run_time_o == REG_RST[IDX_RUN])
        else $error("setting in force outside Modbus mode");

    force_gate_a: assert property (
        1'b1 |=> force_active_o == $past(modbus_mode_i && override_en_i))
        else $error("override active outside its enable");

endmodule
